// ==== core/gctm_edge_if.sv ====
`default_nettype none
interface gctm_edge_if;
   logic level;
   logic rise;
   logic fall;
   modport source (output level, output rise, output fall);
   modport sink   (input level, input rise, input fall);
endinterface
`default_nettype wire

// ==== core/gctm_map.svh ====
`ifndef GCTM_MAP_SVH
`define GCTM_MAP_SVH

// register byte offsets
`define GCTM_ADDR_CTRL     8'h00
`define GCTM_ADDR_DIV      8'h04
`define GCTM_ADDR_RATE     8'h08
`define GCTM_ADDR_COUNT    8'h0C
`define GCTM_ADDR_STAT     8'h10

// control register fields
`define GCTM_CTRL_EN       0
`define GCTM_CTRL_MODE_LO  1
`define GCTM_CTRL_MODE_HI  2
`define GCTM_CTRL_EXT      3
`define GCTM_CTRL_GATE_LO  4
`define GCTM_CTRL_GATE_HI  6
`define GCTM_CTRL_START    7
`define GCTM_CTRL_STOP     8

// mode codes
`define GCTM_MODE_COUNT    2'h0
`define GCTM_MODE_FREQ     2'h1
`define GCTM_MODE_EDGE     2'h2
`define GCTM_MODE_RATE     2'h3

// gate type codes
`define GCTM_GATE_NONE     3'h0
`define GCTM_GATE_LOW      3'h1
`define GCTM_GATE_HIGH     3'h2
`define GCTM_GATE_FALL     3'h3
`define GCTM_GATE_RISE     3'h4

// external divider limits
`define GCTM_DIV_MIN       17'h0_0002
`define GCTM_DIV_MIN_RELAY 17'h0_2580
`define GCTM_DIV_MAX       17'h1_FC02
`define GCTM_DIV_RESET     17'h0_0002

// internal pacing, times in Hz, counts in clk cycles
`define GCTM_SYS_HZ        10000000
`define GCTM_INT_MIN_HZ    4
`define GCTM_INT_MAX_HZ    12000000
`define GCTM_RELAY_MAX_HZ  2500
`define GCTM_RATE_MAX_CYC  (`GCTM_SYS_HZ / `GCTM_INT_MIN_HZ)
`define GCTM_RATE_MIN_FIT  ((`GCTM_SYS_HZ + `GCTM_INT_MAX_HZ - 1) / `GCTM_INT_MAX_HZ)
`define GCTM_RATE_MIN_CYC  ((`GCTM_RATE_MIN_FIT < 2) ? 2 : `GCTM_RATE_MIN_FIT)
`define GCTM_RELAY_MIN_CYC ((`GCTM_SYS_HZ + `GCTM_RELAY_MAX_HZ - 1) / `GCTM_RELAY_MAX_HZ)
`define GCTM_RATE_RESET    32'h0000_0064

`endif

// ==== core/gctm_pkg.sv ====
`default_nettype none
package gctm_pkg;
   typedef enum logic [1:0] {
      MEAS_IDLE,
      MEAS_WAIT,
      MEAS_RUN,
      MEAS_HELD
   } gctm_meas_type;
endpackage
`default_nettype wire

// ==== core/gctm_sync_edge.sv ====
`default_nettype none
module gctm_sync_edge (
   input  wire logic          clk,
   input  wire logic          sys_rst,
   input  wire logic          pinIn,
   gctm_edge_if.source        pinEdge
);
   logic syncA;
   logic syncB;
   logic syncC;

   // syncA feeds only syncB, so a metastable sample never reaches the edge logic
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         syncA <= 1'b1;
         syncB <= 1'b1;
         syncC <= 1'b1;
      end else begin
         syncA <= pinIn;
         syncB <= syncA;
         syncC <= syncB;
      end
   end

   assign pinEdge.level = syncB;
   assign pinEdge.rise  = syncB & ~syncC;
   assign pinEdge.fall  = ~syncB & syncC;
endmodule
`default_nettype wire

// ==== core/gctm_top.sv ====
// What this block does
// - one counter channel, 32-bit count, clock input, gate input, pulse output
// - internal pacing programmable 4 Hz to 5 MHz (period clamped to 2 clk minimum), relay variant 4 Hz to 2.5 kHz
// - external clock divided by 2..130050, relay variant 9600..130050
// - operation on the external clock begins on a falling edge of the counter clock input; internal pacing begins at enable
// - gate none: enabled as soon as software enables, gate ignored
// - low-level gate: run while gate low, stop while high
// - high-level gate: run while gate high, stop while low
// - falling-edge gate: enable on high-to-low gate transition
// - rising-edge gate: enable on low-to-high gate transition
// - pulse output goes high to low; low part is active
// - rate mode duty cycle fixed at half the period
// - event counting: count clock falling edges while level gate active
// - count wraps to zero past full 32 bits and keeps counting
// - frequency measurement counts clock events during known high gate, readable
// - edge mode counts from chosen start gate edge to chosen stop edge
// - after stop edge count holds until re-enabled, stays readable
// - edge mode uses internal time base, one increment per tick
// - rate mode pulses while gate active, stops at once when disabled
// - rate output frequency set by clock source and divider
//
// The register offsets and the address-and-strobe port were left to the implementer.
`include "gctm_map.svh"
`default_nettype none
module gctm_top
   import gctm_pkg::*;
#(
   parameter bit RELAY = 1'b0
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWrData,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output var  logic [31:0] regRdData,
   input  wire logic        ctClkIn,
   input  wire logic        ctGateIn,
   output var  logic        ctOut
);
   localparam logic [31:0] RATE_MIN = RELAY ? 32'(`GCTM_RELAY_MIN_CYC)
                                            : 32'(`GCTM_RATE_MIN_CYC);
   localparam logic [31:0] RATE_MAX = 32'(`GCTM_RATE_MAX_CYC);
   localparam logic [16:0] DIV_MIN  = RELAY ? `GCTM_DIV_MIN_RELAY : `GCTM_DIV_MIN;

   gctm_edge_if clkEdge ();
   gctm_edge_if gateEdge ();

   gctm_sync_edge u_clkSync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .pinIn   (ctClkIn),
      .pinEdge (clkEdge.source)
   );

   gctm_sync_edge u_gateSync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .pinIn   (ctGateIn),
      .pinEdge (gateEdge.source)
   );

   logic          enable;
   logic [1:0]    mode;
   logic          extClk;
   logic [2:0]    gateType;
   logic          startRise;
   logic          stopRise;
   logic [16:0]   divider;
   logic [31:0]   ratePeriod;
   logic [31:0]   count;
   logic          started;
   logic          edgeSeen;
   logic          gateOk;
   logic          active;
   logic [31:0]   pacePhase;
   logic [31:0]   period;
   logic          paceSrc;
   logic          armNow;
   logic          wrCtrl;
   logic          startHit;
   logic          stopHit;
   logic [16:0]   wrDiv;
   logic [31:0]   wrRate;
   gctm_meas_type meas;
   gctm_meas_type next_meas;

   assign wrCtrl = regWr && (regAddr == `GCTM_ADDR_CTRL);
   // a fresh enable restarts every measurement from zero
   assign armNow = wrCtrl && regWrData[`GCTM_CTRL_EN] && !enable;
   assign wrDiv  = regWrData[16:0];
   assign wrRate = regWrData;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         enable    <= 1'b0;
         mode      <= `GCTM_MODE_COUNT;
         extClk    <= 1'b0;
         gateType  <= `GCTM_GATE_NONE;
         startRise <= 1'b0;
         stopRise  <= 1'b0;
      end else if (wrCtrl) begin
         enable    <= regWrData[`GCTM_CTRL_EN];
         mode      <= regWrData[`GCTM_CTRL_MODE_HI:`GCTM_CTRL_MODE_LO];
         extClk    <= regWrData[`GCTM_CTRL_EXT];
         gateType  <= regWrData[`GCTM_CTRL_GATE_HI:`GCTM_CTRL_GATE_LO];
         startRise <= regWrData[`GCTM_CTRL_START];
         stopRise  <= regWrData[`GCTM_CTRL_STOP];
      end
   end

   // out-of-range settings are clamped rather than refused, so the pacer never stalls
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         divider <= (`GCTM_DIV_RESET < DIV_MIN) ? DIV_MIN : `GCTM_DIV_RESET;
      end else if (regWr && regAddr == `GCTM_ADDR_DIV) begin
         if (wrDiv < DIV_MIN || regWrData[31:17] != 15'h0000) begin
            divider <= (regWrData[31:17] != 15'h0000) ? `GCTM_DIV_MAX : DIV_MIN;
         end else if (wrDiv > `GCTM_DIV_MAX) begin
            divider <= `GCTM_DIV_MAX;
         end else begin
            divider <= wrDiv;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ratePeriod <= (`GCTM_RATE_RESET < RATE_MIN) ? RATE_MIN : `GCTM_RATE_RESET;
      end else if (regWr && regAddr == `GCTM_ADDR_RATE) begin
         if (wrRate < RATE_MIN) begin
            ratePeriod <= RATE_MIN;
         end else if (wrRate > RATE_MAX) begin
            ratePeriod <= RATE_MAX;
         end else begin
            ratePeriod <= wrRate;
         end
      end
   end

   // operations on the external clock wait for its first falling edge
   always_ff @(posedge clk) begin
      if (sys_rst || !enable || armNow) begin
         started <= 1'b0;
      end else if (!extClk || clkEdge.fall) begin
         started <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || !enable) begin
         edgeSeen <= 1'b0;
      end else if (gateType == `GCTM_GATE_FALL && gateEdge.fall) begin
         edgeSeen <= 1'b1;
      end else if (gateType == `GCTM_GATE_RISE && gateEdge.rise) begin
         edgeSeen <= 1'b1;
      end
   end

   always_comb begin
      unique case (gateType)
         `GCTM_GATE_NONE: gateOk = 1'b1;
         `GCTM_GATE_LOW:  gateOk = !gateEdge.level;
         `GCTM_GATE_HIGH: gateOk = gateEdge.level;
         `GCTM_GATE_FALL: gateOk = edgeSeen;
         `GCTM_GATE_RISE: gateOk = edgeSeen;
         default:         gateOk = 1'b0;
      endcase
   end

   // the falling edge that starts an external-clock operation already counts
   assign active = enable && gateOk && (started || (extClk && clkEdge.fall));

   // edge-to-edge interval state
   assign startHit = startRise ? gateEdge.rise : gateEdge.fall;
   assign stopHit  = stopRise ? gateEdge.rise : gateEdge.fall;

   always_comb begin
      next_meas = meas;
      unique case (meas)
         MEAS_IDLE: if (armNow && regWrData[`GCTM_CTRL_MODE_HI:`GCTM_CTRL_MODE_LO]
                        == `GCTM_MODE_EDGE) next_meas = MEAS_WAIT;
         MEAS_WAIT: if (startHit) next_meas = MEAS_RUN;
         MEAS_RUN:  if (stopHit) next_meas = MEAS_HELD;
         MEAS_HELD: next_meas = MEAS_HELD;
      endcase
      if (!enable && !armNow) begin
         next_meas = MEAS_IDLE;
      end
      if (mode != `GCTM_MODE_EDGE && meas != MEAS_IDLE) begin
         next_meas = MEAS_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meas <= MEAS_IDLE;
      end else begin
         meas <= next_meas;
      end
   end

   // the 32-bit count wraps through zero by plain modular add
   always_ff @(posedge clk) begin
      if (sys_rst || armNow) begin
         count <= 32'h0000_0000;
      end else begin
         unique case (mode)
            `GCTM_MODE_COUNT: if (active && clkEdge.fall)
                                 count <= count + 32'h0000_0001;
            `GCTM_MODE_FREQ:  if (active && clkEdge.fall) count <= count + 32'h0000_0001;
            // one tick of the system clock is the internal time base
            `GCTM_MODE_EDGE:  if (meas == MEAS_RUN) count <= count + 32'h0000_0001;
            `GCTM_MODE_RATE:  if (active && paceSrc && pacePhase == period - 32'h0000_0001)
                                 count <= count + 32'h0000_0001;
         endcase
      end
   end

   // rate generation pacer
   assign paceSrc = extClk ? clkEdge.fall : 1'b1;
   assign period  = extClk ? {15'h0000, divider} : ratePeriod;

   always_ff @(posedge clk) begin
      if (sys_rst || !active || mode != `GCTM_MODE_RATE) begin
         pacePhase <= 32'h0000_0000;
      end else if (paceSrc) begin
         pacePhase <= (pacePhase >= period - 32'h0000_0001) ? 32'h0000_0000
                                                            : pacePhase + 32'h0000_0001;
      end
   end

   // low half of each period is the active part; idle level is high
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctOut <= 1'b1;
      end else if (!active || mode != `GCTM_MODE_RATE) begin
         ctOut <= 1'b1;
      end else begin
         ctOut <= !(pacePhase < (period >> 1));
      end
   end

   // reads snapshot the count; they never touch counting state
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         regRdData <= 32'h0000_0000;
      end else if (regRd) begin
         unique case (regAddr)
            `GCTM_ADDR_CTRL:  regRdData <= {23'h00_0000, stopRise, startRise, gateType,
                                            extClk, mode, enable};
            `GCTM_ADDR_DIV:   regRdData <= {15'h0000, divider};
            `GCTM_ADDR_RATE:  regRdData <= ratePeriod;
            `GCTM_ADDR_COUNT: regRdData <= count;
            `GCTM_ADDR_STAT:  regRdData <= {26'h000_0000, gateEdge.level, ctOut,
                                            meas == MEAS_HELD, meas == MEAS_RUN,
                                            started, active};
            default:          regRdData <= 32'h0000_0000;
         endcase
      end else begin
         regRdData <= 32'h0000_0000;
      end
   end

   chk_count_inc: assert property (@(posedge clk) disable iff (sys_rst)
      (mode == `GCTM_MODE_COUNT && active && clkEdge.fall && !armNow)
      |=> count == $past(count) + 32'h0000_0001)
      else $error("event count missed a clock falling edge");

   chk_count_wrap: assert property (@(posedge clk) disable iff (sys_rst)
      (mode == `GCTM_MODE_COUNT && active && clkEdge.fall && !armNow
       && count == 32'hFFFF_FFFF) |=> count == 32'h0000_0000)
      else $error("count did not wrap to zero");

   chk_start_fall: assert property (@(posedge clk) disable iff (sys_rst)
      (enable && extClk && !started && !clkEdge.fall) |=> !started)
      else $error("operation started without a clock falling edge");

   chk_gate_none: assert property (@(posedge clk) disable iff (sys_rst)
      (wrCtrl && regWrData[`GCTM_CTRL_EN]
       && regWrData[`GCTM_CTRL_GATE_HI:`GCTM_CTRL_GATE_LO] == `GCTM_GATE_NONE
       && !regWrData[`GCTM_CTRL_EXT]) ##1 !wrCtrl |=> active)
      else $error("ungated operation not enabled");

   chk_gate_low: assert property (@(posedge clk) disable iff (sys_rst)
      (mode == `GCTM_MODE_COUNT && gateType == `GCTM_GATE_LOW && gateEdge.level && !armNow)
      |=> $stable(count))
      else $error("low-level gate ran with gate high");

   chk_gate_high: assert property (@(posedge clk) disable iff (sys_rst)
      (mode == `GCTM_MODE_COUNT && gateType == `GCTM_GATE_HIGH && !gateEdge.level && !armNow)
      |=> $stable(count))
      else $error("high-level gate ran with gate low");

   chk_gate_fall: assert property (@(posedge clk) disable iff (sys_rst)
      (gateType == `GCTM_GATE_FALL && enable && gateEdge.fall && !wrCtrl) |=> edgeSeen)
      else $error("falling gate edge not latched");

   chk_gate_rise: assert property (@(posedge clk) disable iff (sys_rst)
      (gateType == `GCTM_GATE_RISE && enable && gateEdge.rise && !wrCtrl) |=> edgeSeen)
      else $error("rising gate edge not latched");

   chk_edge_run: assert property (@(posedge clk) disable iff (sys_rst)
      (mode == `GCTM_MODE_EDGE && meas == MEAS_RUN && !armNow)
      |=> count == $past(count) + 32'h0000_0001)
      else $error("interval count not incrementing");

   chk_edge_hold: assert property (@(posedge clk) disable iff (sys_rst)
      (mode == `GCTM_MODE_EDGE && meas == MEAS_HELD && !armNow) |=> $stable(count))
      else $error("held interval count changed");

   chk_rate_stop: assert property (@(posedge clk) disable iff (sys_rst)
      (!active) |=> ctOut)
      else $error("pulse output active while disabled");

   chk_rate_half: assert property (@(posedge clk) disable iff (sys_rst)
      (mode == `GCTM_MODE_RATE && active && pacePhase >= (period >> 1)) |=> ctOut)
      else $error("output not high in second half of period");

   chk_rate_low: assert property (@(posedge clk) disable iff (sys_rst)
      (mode == `GCTM_MODE_RATE && active && pacePhase < (period >> 1)) |=> !ctOut)
      else $error("output not low in first half of period");

   chk_div_range: assert property (@(posedge clk) disable iff (sys_rst)
      divider >= DIV_MIN && divider <= `GCTM_DIV_MAX)
      else $error("divider outside its range");

   chk_read_count: assert property (@(posedge clk) disable iff (sys_rst)
      (regRd && regAddr == `GCTM_ADDR_COUNT) |=> regRdData == $past(count))
      else $error("count read returned a wrong value");

   chk_freq_inc: assert property (@(posedge clk) disable iff (sys_rst)
      (mode == `GCTM_MODE_FREQ && active && clkEdge.fall && !armNow)
      |=> count == $past(count) + 32'h0000_0001)
      else $error("frequency count missed a clock falling edge");

   chk_edge_wait: assert property (@(posedge clk) disable iff (sys_rst)
      (mode == `GCTM_MODE_EDGE && meas == MEAS_WAIT && !armNow) |=> $stable(count))
      else $error("interval count moved before its start edge");

   chk_read_idle: assert property (@(posedge clk) disable iff (sys_rst)
      (!regRd) |=> regRdData == 32'h0000_0000)
      else $error("read data not zero outside a read");

   chk_arm_clear: assert property (@(posedge clk) disable iff (sys_rst)
      armNow |=> count == 32'h0000_0000)
      else $error("count not cleared by a new enable");
endmodule
`default_nettype wire

// ==== test/gctm_far_end.sv ====
`default_nettype none
module gctm_far_end (
   input  wire logic clk,
   output var  logic ctClkIn,
   output var  logic ctGateIn,
   input  wire logic ctOut
);
   timeunit 1ns;
   timeprecision 1ps;

   // counter clock idles high and only moves while a task drives it
   initial begin
      ctClkIn = 1'b1;
      ctGateIn = 1'b0;
   end

   // each level held 3 clk, well inside what the synchroniser resolves
   task automatic edges(input int n);
      repeat (n) begin
         @(posedge clk) ctClkIn <= 1'b0;
         repeat (3) @(posedge clk);
         ctClkIn <= 1'b1;
         repeat (2) @(posedge clk);
      end
   endtask

   task automatic gate(input logic v);
      @(posedge clk) ctGateIn <= v;
   endtask
endmodule
`default_nettype wire

// ==== test/tb_gated_counter_timer.sv ====
`default_nettype none
module tb_gated_counter_timer;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk = 1'b0;
   logic        sysRst = 1'b1;
   logic [7:0]  regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0000_0000;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   logic [31:0] regRdData;
   logic        ctClkIn;
   logic        ctGateIn;
   logic        ctOut;
   int          n_fail = 0;
   int          n_checks = 0;
   int          cycles = 0;

   always #50 clk = ~clk;

   gctm_top dut (
      .clk       (clk),
      .sys_rst   (sysRst),
      .regAddr   (regAddr),
      .regWrData (regWrData),
      .regWr     (regWr),
      .regRd     (regRd),
      .regRdData (regRdData),
      .ctClkIn   (ctClkIn),
      .ctGateIn  (ctGateIn),
      .ctOut     (ctOut)
   );

   gctm_far_end far (
      .clk      (clk),
      .ctClkIn  (ctClkIn),
      .ctGateIn (ctGateIn),
      .ctOut    (ctOut)
   );

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) begin
         regWr <= 1'b1;
         regAddr <= a;
         regWrData <= d;
      end
      @(posedge clk) regWr <= 1'b0;
   endtask

   // data of a read stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk) begin
         regRd <= 1'b1;
         regAddr <= a;
      end
      @(posedge clk) regRd <= 1'b0;
      @(posedge clk) d = regRdData;
   endtask

   task automatic run_len(input logic v, output int n);
      n = 0;
      while (ctOut === v && n < 200) begin
         @(posedge clk);
         n++;
      end
   endtask

   task automatic test_regs();
      logic [31:0] d;
      chk("idle output", 32'h0000_0001, {31'h0, ctOut});
      rd(8'h00, d);
      chk("ctrl reset", 32'h0000_0000, d);
      rd(8'h04, d);
      chk("div reset", 32'h0000_0002, d);
      rd(8'h08, d);
      chk("rate reset", 32'h0000_0064, d);
      rd(8'h0C, d);
      chk("count reset", 32'h0000_0000, d);
      rd(8'h20, d);
      chk("unmapped read", 32'h0000_0000, d);
      wr(8'h04, 32'h0000_0001);
      rd(8'h04, d);
      chk("div low clamp", 32'h0000_0002, d);
      wr(8'h04, 32'h0002_0000);
      rd(8'h04, d);
      chk("div high clamp", 32'h0001_FC02, d);
      $display("test regs done");
   endtask

   // ext clock, level or no gate: 4 edges, read, 4 more edges
   task automatic count_gate(input logic [1:0] m, input logic [2:0] g, input logic lvl,
                             input logic on);
      logic [31:0] d;
      wr(8'h00, 32'h0000_0000);
      far.gate(lvl);
      repeat (6) @(posedge clk);
      wr(8'h00, {23'h0, 1'b0, 1'b0, g, 1'b1, m, 1'b1});
      far.edges(4);
      repeat (6) @(posedge clk);
      rd(8'h0C, d);
      chk("count mid", on ? 32'h0000_0004 : 32'h0000_0000, d);
      far.edges(4);
      repeat (6) @(posedge clk);
      rd(8'h0C, d);
      chk("count end", on ? 32'h0000_0008 : 32'h0000_0000, d);
   endtask

   // edge gates: clock edges before the gate edge are ignored, those after it counted
   task automatic test_gate_edge();
      logic [31:0] d;
      for (int r = 0; r < 2; r++) begin
         wr(8'h00, 32'h0000_0000);
         far.gate(!r[0]);
         repeat (6) @(posedge clk);
         wr(8'h00, {23'h0, 2'b00, r[0] ? 3'h4 : 3'h3, 1'b1, 2'h0, 1'b1});
         far.edges(2);
         repeat (6) @(posedge clk);
         rd(8'h0C, d);
         chk("count before gate edge", 32'h0000_0000, d);
         far.gate(r[0]);
         repeat (6) @(posedge clk);
         far.edges(3);
         repeat (6) @(posedge clk);
         rd(8'h0C, d);
         chk("count after gate edge", 32'h0000_0003, d);
      end
      $display("test gate edge done");
   endtask

   task automatic test_count();
      count_gate(2'h0, 3'h0, 1'b1, 1'b1);
      count_gate(2'h0, 3'h1, 1'b0, 1'b1);
      count_gate(2'h0, 3'h1, 1'b1, 1'b0);
      count_gate(2'h0, 3'h2, 1'b1, 1'b1);
      count_gate(2'h0, 3'h2, 1'b0, 1'b0);
      count_gate(2'h1, 3'h2, 1'b1, 1'b1);
      $display("test count done");
   endtask

   // start edge s, stop edge the opposite one, 40 clk apart
   task automatic test_edge();
      logic [31:0] d;
      logic [31:0] held;
      for (int s = 0; s < 2; s++) begin
         wr(8'h00, 32'h0000_0000);
         far.gate(!s[0]);
         repeat (6) @(posedge clk);
         wr(8'h00, {23'h0, !s[0], s[0], 3'h0, 1'b0, 2'h2, 1'b1});
         repeat (5) @(posedge clk);
         far.gate(s[0]);
         repeat (39) @(posedge clk);
         far.gate(!s[0]);
         repeat (8) @(posedge clk);
         rd(8'h0C, held);
         chk("interval", 32'h0000_0001, {31'h0, held >= 39 && held <= 41});
         repeat (20) @(posedge clk);
         rd(8'h0C, d);
         chk("held count", held, d);
      end
      $display("test edge done");
   endtask

   task automatic test_rate();
      int lo;
      int hi;
      int n;
      wr(8'h08, 32'h0000_000A);
      wr(8'h00, 32'h0000_0007);
      run_len(1'b1, n);
      run_len(1'b0, lo);
      run_len(1'b1, hi);
      chk("low width", 32'd5, lo);
      chk("high width", 32'd5, hi);
      wr(8'h00, 32'h0000_0000);
      repeat (3) @(posedge clk);
      run_len(1'b1, n);
      chk("stopped", 32'd200, n);
      far.gate(1'b0);
      repeat (6) @(posedge clk);
      wr(8'h00, 32'h0000_0027);
      run_len(1'b1, n);
      chk("gate low holds", 32'd200, n);
      $display("test rate done");
   endtask

   task automatic close_out();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // whole run is a little over a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         close_out();
      end
   end

   initial begin
      repeat (2) @(posedge clk);
      sysRst <= 1'b0;
      @(posedge clk);
      test_regs();
      test_count();
      test_gate_edge();
      test_edge();
      test_rate();
      close_out();
   end
endmodule
`default_nettype wire
